// ---- design/flash_sec_pkg.sv ----
// constants, types and decode helpers shared by the flash security block
package flash_sec_pkg;

    // ----------------------------------------------------------------
    // bus and address map
    // ----------------------------------------------------------------
    localparam int          ADDR_W        = 16;       // cpu address width
    localparam int          DATA_W        = 8;        // cpu data width
    localparam int          KEY_BYTES     = 8;        // bytes in the comparison key
    localparam logic [15:0] KEY_BASE_ADDR = 16'hffb0; // first key byte address
    localparam logic [15:0] KEY_LAST_ADDR = 16'hffb7; // last key byte address
    localparam logic [15:0] CONFIG_ADDR   = 16'h0023; // flash_config register
    localparam logic [15:0] STATUS_ADDR   = 16'h0024; // security status register

    // ----------------------------------------------------------------
    // field layout and reset values
    // ----------------------------------------------------------------
    localparam int          KEY_EN_BIT     = 5;        // access-key enable in flash_config
    localparam logic [7:0]  CONFIG_WR_MASK = 8'he0;    // bits 7..5 writable, 4..0 zero
    localparam logic [7:0]  CONFIG_RESET   = 8'h00;    // flash_config after reset
    localparam logic [1:0]  SEC_UNSECURED  = 2'h2;     // the one open pattern, 1:0
    localparam logic [1:0]  SEC_RESET      = 2'h0;     // secured until the field loads
    localparam logic [7:0]  MASK_FULL      = 8'hff;    // every key byte written

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef struct packed {
        logic [15:0] addr;                             // address of the starting write
        logic [7:0]  data;                             // data of the starting write
    } cmd_s;

    typedef enum logic [1:0] {
        KEY_IDLE,                                      // no key bytes held
        KEY_COLLECT,                                   // some key bytes held
        KEY_CHECK                                      // all bytes held, compare now
    } key_phase_e;

    // ----------------------------------------------------------------
    // decode helpers
    // ----------------------------------------------------------------
    function automatic logic is_key_addr(input logic [15:0] addr);
        is_key_addr = (addr >= KEY_BASE_ADDR) && (addr <= KEY_LAST_ADDR);
    endfunction : is_key_addr

    function automatic logic is_unsecured(input logic [1:0] sec);
        is_unsecured = (sec == SEC_UNSECURED);
    endfunction : is_unsecured

endpackage : flash_sec_pkg

// ---- design/flash_security_key_access.sv ----
// security decode, flash_config register and backdoor key write steering
//
// Overview of operation
// - only pattern 1:0 means unsecured; success unsecures
// - flash_config bits 7..5 always read/write
// - flash_config bits 4..0 read zero, ignore writes
// - key range write, enable 0: starts flash command
// - key range write, enable 1: captures key byte, except in the compare cycle
`timescale 1ns/10ps

module flash_security_key_access (
    input  wire logic                 SYS_CLK_I,       // 100 MHz system clock
    input  wire logic                 RST_N_I,         // async reset, active low
    input  wire logic [15:0]          ADDR_I,          // cpu address
    input  wire logic [7:0]           WDATA_I,         // cpu write data
    input  wire logic                 WR_I,            // write strobe
    input  wire logic                 RD_I,            // read strobe
    output logic      [7:0]           RDATA_O,         // read data, cycle after RD_I
    input  wire logic [1:0]           SEC_FIELD_I,     // nonvolatile security field
    input  wire logic                 BLANK_OK_I,      // pulse: blank check passed
    input  wire logic [63:0]          BACKDOOR_KEY_I,  // stored backdoor_compare_key
    output logic                      CMD_START_O,     // pulse: flash command begins
    output flash_sec_pkg::cmd_s       CMD_O,           // write that began the command
    output logic      [1:0]           SEC_STATE_O,     // security_state_field
    output logic                      SECURED_O,       // part is secured
    output logic                      KEY_OK_O         // pulse: key entry succeeded
);

    // ----------------------------------------------------------------
    // declarations
    // ----------------------------------------------------------------
    logic [7:0]                cfg_r;                  // flash_config contents
    logic                      loaded_r;               // field sampled after reset
    logic [1:0]                sec_r;                  // security_state_field
    logic [1:0]                sec_nxt;
    logic                      secured_r;              // decoded secure flag
    logic [7:0]                key_r [8];              // captured comparison bytes
    logic [7:0]                mask_r;                 // which bytes were written
    logic [7:0]                mask_nxt;
    flash_sec_pkg::key_phase_e phase_r;                // key entry progress
    flash_sec_pkg::key_phase_e phase_nxt;
    logic [63:0]               key_flat;               // captured bytes, byte 0 low
    logic                      key_en;                 // access-key enable bit
    logic                      in_key;                 // address in key range
    logic                      key_wr;                 // write captured as key byte
    logic                      cmd_wr;                 // write starting a command
    logic                      key_match;              // compare succeeded this cycle
    logic                      cmd_start_r;
    flash_sec_pkg::cmd_s       cmd_r;
    logic [7:0]                rdata_r;
    logic                      key_ok_r;

    // ----------------------------------------------------------------
    // write steering
    // ----------------------------------------------------------------
    assign key_en = cfg_r[flash_sec_pkg::KEY_EN_BIT];
    assign in_key = flash_sec_pkg::is_key_addr(ADDR_I);
    // the enable bit alone decides; a config write never hits the key range
    assign key_wr = WR_I && in_key && key_en;
    assign cmd_wr = WR_I && in_key && !key_en;

    // ----------------------------------------------------------------
    // flash_config register
    // ----------------------------------------------------------------
    // no lock on security or command activity: writable every cycle
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            cfg_r <= flash_sec_pkg::CONFIG_RESET;
        else if (WR_I && (ADDR_I == flash_sec_pkg::CONFIG_ADDR))
            cfg_r <= WDATA_I & flash_sec_pkg::CONFIG_WR_MASK;
    end

    // ----------------------------------------------------------------
    // key capture and compare
    // ----------------------------------------------------------------
    // flatten bytes so byte 0 (lowest address) sits in bits 7..0
    always_comb
    begin
        key_flat = '0;
        for (int i = 0; i < flash_sec_pkg::KEY_BYTES; i++)
            key_flat[8*i +: 8] = key_r[i];
    end

    assign key_match = (phase_r == flash_sec_pkg::KEY_CHECK) &&
                       (key_flat == BACKDOOR_KEY_I);

    // next mask and phase; writes in the compare cycle are dropped
    always_comb
    begin
        mask_nxt  = mask_r;
        phase_nxt = phase_r;
        case (phase_r)
            flash_sec_pkg::KEY_IDLE,
            flash_sec_pkg::KEY_COLLECT:
            begin
                if (key_wr)
                begin
                    mask_nxt  = mask_r | (8'h01 << ADDR_I[2:0]);
                    phase_nxt = (mask_nxt == flash_sec_pkg::MASK_FULL) ?
                                flash_sec_pkg::KEY_CHECK : flash_sec_pkg::KEY_COLLECT;
                end
            end
            flash_sec_pkg::KEY_CHECK:
            begin
                // one try per eight bytes; a miss just starts over
                mask_nxt  = '0;
                phase_nxt = flash_sec_pkg::KEY_IDLE;
            end
            default:
            begin
                mask_nxt  = '0;
                phase_nxt = flash_sec_pkg::KEY_IDLE;
            end
        endcase
    end

    // progress state of key entry
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            mask_r  <= '0;
            phase_r <= flash_sec_pkg::KEY_IDLE;
        end
        else
        begin
            mask_r  <= mask_nxt;
            phase_r <= phase_nxt;
        end
    end

    // byte storage, no reset needed: mask says what is valid
    always_ff @(posedge SYS_CLK_I)
    begin
        if (key_wr && (phase_r != flash_sec_pkg::KEY_CHECK))
            key_r[ADDR_I[2:0]] <= WDATA_I;
    end

    // ----------------------------------------------------------------
    // security state
    // ----------------------------------------------------------------
    // a success wins over the field load so an early blank check is kept
    always_comb
    begin
        sec_nxt = sec_r;
        if (key_match || BLANK_OK_I)
            sec_nxt = flash_sec_pkg::SEC_UNSECURED;
        else if (!loaded_r)
            sec_nxt = SEC_FIELD_I;
    end

    // field is caught by a clock edge after release, never by the reset
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            loaded_r  <= 1'b0;
            sec_r     <= flash_sec_pkg::SEC_RESET;
            secured_r <= 1'b1;
        end
        else
        begin
            loaded_r  <= 1'b1;
            sec_r     <= sec_nxt;
            secured_r <= !flash_sec_pkg::is_unsecured(sec_nxt);
        end
    end

    // ----------------------------------------------------------------
    // command start and key result outputs
    // ----------------------------------------------------------------
    // the command sequencer sees the first write, one cycle late
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
        begin
            cmd_start_r <= 1'b0;
            cmd_r       <= '0;
            key_ok_r    <= 1'b0;
        end
        else
        begin
            cmd_start_r <= cmd_wr;
            key_ok_r    <= key_match;
            if (cmd_wr)
                cmd_r <= '{addr: ADDR_I, data: WDATA_I};
        end
    end

    // ----------------------------------------------------------------
    // read port
    // ----------------------------------------------------------------
    // data stand one cycle only; unmapped addresses read zero
    always_ff @(posedge SYS_CLK_I or negedge RST_N_I)
    begin
        if (!RST_N_I)
            rdata_r <= '0;
        else if (RD_I && (ADDR_I == flash_sec_pkg::CONFIG_ADDR))
            rdata_r <= cfg_r;
        else if (RD_I && (ADDR_I == flash_sec_pkg::STATUS_ADDR))
            rdata_r <= {5'h00, secured_r, sec_r};
        else
            rdata_r <= '0;
    end

    assign RDATA_O     = rdata_r;
    assign CMD_START_O = cmd_start_r;
    assign CMD_O       = cmd_r;
    assign SEC_STATE_O = sec_r;
    assign SECURED_O   = secured_r;
    assign KEY_OK_O    = key_ok_r;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    property p_secure_decode;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        loaded_r |-> (SECURED_O == (SEC_STATE_O != flash_sec_pkg::SEC_UNSECURED));
    endproperty
    a_secure_decode: assert property (p_secure_decode)
        else $error("secured flag disagrees with security field");

    property p_blank_unsecures;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        BLANK_OK_I |=> (SEC_STATE_O == flash_sec_pkg::SEC_UNSECURED) && !SECURED_O;
    endproperty
    a_blank_unsecures: assert property (p_blank_unsecures)
        else $error("blank check did not unsecure");

    sequence s_cfg_write;
        WR_I && (ADDR_I == flash_sec_pkg::CONFIG_ADDR);
    endsequence
    sequence s_cfg_read;
        RD_I && (ADDR_I == flash_sec_pkg::CONFIG_ADDR);
    endsequence

    // a read right behind a write must already see the new upper bits
    property p_cfg_rw;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s_cfg_write ##1 s_cfg_read |=>
            ((RDATA_O & flash_sec_pkg::CONFIG_WR_MASK) ==
             ($past(WDATA_I, 2) & flash_sec_pkg::CONFIG_WR_MASK));
    endproperty
    a_cfg_rw: assert property (p_cfg_rw)
        else $error("flash_config upper bits did not read back");

    property p_cfg_low_zero;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s_cfg_read |=> (RDATA_O[4:0] == 5'h00);
    endproperty
    a_cfg_low_zero: assert property (p_cfg_low_zero)
        else $error("flash_config low bits read nonzero");

    property p_cmd_start;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (WR_I && flash_sec_pkg::is_key_addr(ADDR_I) && !cfg_r[flash_sec_pkg::KEY_EN_BIT])
        |=> CMD_START_O && (CMD_O.addr == $past(ADDR_I)) && (CMD_O.data == $past(WDATA_I));
    endproperty
    a_cmd_start: assert property (p_cmd_start)
        else $error("key range write did not start a command");

    property p_key_capture;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        (WR_I && flash_sec_pkg::is_key_addr(ADDR_I) && cfg_r[flash_sec_pkg::KEY_EN_BIT])
        |=> !CMD_START_O;
    endproperty
    a_key_capture: assert property (p_key_capture)
        else $error("key byte write started a command");

    sequence s_check_hit;
        (phase_r == flash_sec_pkg::KEY_CHECK) && (key_flat == BACKDOOR_KEY_I);
    endsequence
    sequence s_check_miss;
        (phase_r == flash_sec_pkg::KEY_CHECK) && (key_flat != BACKDOOR_KEY_I) && !BLANK_OK_I;
    endsequence

    property p_key_hit;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s_check_hit |=> KEY_OK_O && !SECURED_O && (phase_r == flash_sec_pkg::KEY_IDLE);
    endproperty
    a_key_hit: assert property (p_key_hit)
        else $error("matching key did not unsecure");

    property p_key_miss;
        @(posedge SYS_CLK_I) disable iff (!RST_N_I)
        s_check_miss |=> !KEY_OK_O && (SEC_STATE_O == $past(sec_r)) && (mask_r == 8'h00);
    endproperty
    a_key_miss: assert property (p_key_miss)
        else $error("wrong key changed security state");

endmodule : flash_security_key_access

// ---- sim/tb_top.sv ----
// self-checking testbench for the flash security and key steering block
`timescale 1ns/10ps

module tb_top;

    // ----------------------------------------------------------------
    // constants and stimulus signals
    // ----------------------------------------------------------------
    localparam logic [63:0] STORED_KEY = 64'h0123_4567_89ab_cdef; // arbitrary stored key
    localparam int          CYCLE_CAP  = 2000;                    // run is under two hundred cycles

    logic                 clk;         // 100 MHz system clock
    logic                 rst_n;       // async reset, active low
    logic [15:0]          addr;        // cpu address
    logic [7:0]           wdata;       // cpu write data
    logic                 wr;          // write strobe
    logic                 rd;          // read strobe
    logic [7:0]           rdata;       // read data
    logic [1:0]           sec_field;   // nonvolatile security field
    logic                 blank_ok;    // blank check passed pulse
    logic                 cmd_start;   // flash command start pulse
    flash_sec_pkg::cmd_s  cmd;         // write that started the command
    logic [1:0]           sec_state;   // decoded security field
    logic                 secured;     // part secured
    logic                 key_ok;      // key entry matched pulse
    int                   miscompares; // mismatches seen
    int                   n_checks;    // comparisons made
    int                   cycles = 0;  // hang guard

    // ----------------------------------------------------------------
    // device under test and clock
    // ----------------------------------------------------------------
    flash_security_key_access dut (
        .SYS_CLK_I      (clk),
        .RST_N_I        (rst_n),
        .ADDR_I         (addr),
        .WDATA_I        (wdata),
        .WR_I           (wr),
        .RD_I           (rd),
        .RDATA_O        (rdata),
        .SEC_FIELD_I    (sec_field),
        .BLANK_OK_I     (blank_ok),
        .BACKDOOR_KEY_I (STORED_KEY),
        .CMD_START_O    (cmd_start),
        .CMD_O          (cmd),
        .SEC_STATE_O    (sec_state),
        .SECURED_O      (secured),
        .KEY_OK_O       (key_ok)
    );

    // free-running clock, 10 ns period
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ----------------------------------------------------------------
    // shared tasks
    // ----------------------------------------------------------------
    // one comparison; four-state inequality so an unknown never matches
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // reset held 12 cycles; the field loads at the first edge after release
    task automatic do_reset(input logic [1:0] field);
        @(posedge clk);
        rst_n     <= 1'b0;
        sec_field <= field;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
    endtask : do_reset

    // single write cycle; returns just after the edge that took it
    task automatic bus_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask : bus_wr

    // single read cycle; data are looked at in the one cycle they stand
    task automatic bus_rd(input logic [15:0] a, input logic [7:0] exp, input string what);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, {24'h0, rdata}, {24'h0, exp});
    endtask : bus_rd

    // enter eight key bytes; a byte index equal to bad gets flipped bits
    task automatic enter_key(input int bad);
        logic [7:0] b;
        for (int i = 0; i < flash_sec_pkg::KEY_BYTES; i++)
        begin
            b = STORED_KEY[8*i +: 8] ^ ((i == bad) ? 8'h5a : 8'h00);
            bus_wr(flash_sec_pkg::KEY_BASE_ADDR + 16'(i), b);
            chk("no cmd in key mode", {31'h0, cmd_start}, 32'h0);
        end
    endtask : enter_key

    // watch a few cycles for the match pulse
    task automatic watch_key_ok(input logic exp);
        logic seen;
        seen = 1'b0;
        repeat (4)
        begin
            @(posedge clk);
            #1;
            if (key_ok === 1'b1)
                seen = 1'b1;
        end
        chk("key_ok pulse", {31'h0, seen}, {31'h0, exp});
    endtask : watch_key_ok

    // verdict and end of run, reached from the sequence or the guard
    task automatic conclude();
        if (miscompares == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    // every field pattern after reset; only 1:0 opens the part
    task automatic t_decode();
        for (int p = 0; p < 4; p++)
        begin
            do_reset(2'(p));
            chk("sec_state", {30'h0, sec_state}, 32'(p));
            chk("secured", {31'h0, secured}, {31'h0, (p != 2)});
            bus_rd(flash_sec_pkg::STATUS_ADDR, {5'h0, (p != 2), 2'(p)}, "status");
        end
    endtask : t_decode

    // config bits 7..5 store, 4..0 read zero, strays ignored
    task automatic t_config();
        bus_rd(flash_sec_pkg::CONFIG_ADDR, 8'h00, "cfg reset");
        bus_wr(flash_sec_pkg::CONFIG_ADDR, 8'hff);
        bus_rd(flash_sec_pkg::CONFIG_ADDR, 8'he0, "cfg all ones");
        bus_wr(flash_sec_pkg::CONFIG_ADDR, 8'h5f);
        bus_rd(flash_sec_pkg::CONFIG_ADDR, 8'h40, "cfg mixed");
        // write then read with no idle cycle between the strobes
        @(posedge clk);
        addr  <= flash_sec_pkg::CONFIG_ADDR;
        wdata <= 8'h9f;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("cfg back to back", {24'h0, rdata}, 32'h00000080);
        bus_wr(16'h0030, 8'hff);
        bus_rd(16'h0030, 8'h00, "unmapped");
        bus_rd(flash_sec_pkg::KEY_BASE_ADDR, 8'h00, "key range read");
        bus_wr(flash_sec_pkg::CONFIG_ADDR, 8'h00);
        bus_rd(flash_sec_pkg::CONFIG_ADDR, 8'h00, "cfg cleared");
    endtask : t_config

    // enable 0: in-range writes start a command, addresses just outside the range do not
    task automatic t_command();
        bus_wr(16'hffb3, 8'h5a);
        chk("cmd start", {31'h0, cmd_start}, 32'h1);
        chk("cmd word", {8'h0, cmd}, {8'h0, 16'hffb3, 8'h5a});
        @(posedge clk);
        #1;
        chk("cmd pulse ends", {31'h0, cmd_start}, 32'h0);
        bus_wr(16'hffaf, 8'h11);
        chk("below range", {31'h0, cmd_start}, 32'h0);
        bus_wr(16'hffb8, 8'h22);
        chk("above range", {31'h0, cmd_start}, 32'h0);
        bus_wr(flash_sec_pkg::KEY_LAST_ADDR, 8'h33);
        chk("last key addr", {31'h0, cmd_start}, 32'h1);
    endtask : t_command

    // enable 1: a wrong key keeps the part closed, the right one opens it
    task automatic t_key();
        do_reset(2'h3);
        bus_wr(flash_sec_pkg::CONFIG_ADDR, 8'h20);
        enter_key(7);
        watch_key_ok(1'b0);
        chk("still secured", {31'h0, secured}, 32'h1);
        enter_key(-1);
        watch_key_ok(1'b1);
        chk("opened state", {30'h0, sec_state}, 32'h2);
        chk("opened", {31'h0, secured}, 32'h0);
    endtask : t_key

    // blank check pass opens a secured part
    task automatic t_blank();
        do_reset(2'h1);
        @(posedge clk);
        blank_ok <= 1'b1;
        @(posedge clk);
        blank_ok <= 1'b0;
        @(posedge clk);
        #1;
        chk("blank state", {30'h0, sec_state}, 32'h2);
        chk("blank open", {31'h0, secured}, 32'h0);
    endtask : t_blank

    // ----------------------------------------------------------------
    // main sequence and hang guard
    // ----------------------------------------------------------------
    initial
    begin
        rst_n       = 1'b0;
        addr        = 16'h0000;
        wdata       = 8'h00;
        wr          = 1'b0;
        rd          = 1'b0;
        sec_field   = 2'h0;
        blank_ok    = 1'b0;
        miscompares = 0;
        n_checks    = 0;
        t_decode();
        t_config();
        t_command();
        t_key();
        t_blank();
        conclude();
    end

    // a stuck run counts as a mismatch and still reports
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles >= CYCLE_CAP)
        begin
            miscompares++;
            conclude();
        end
    end

endmodule : tb_top
